//--- hdl/dht_conv.v
`timescale 1ns/1ns
`include "dht_regs.vh"
module dht_conv (
    input  wire        clk,
    input  wire        reset,
    input  wire        start,
    input  wire [15:0] size,
    input  wire [5:0]  bpp,
    input  wire [2:0]  width,
    output wire        done,
    output wire [15:0] result
);
    reg  [22:0] rem_reg;
    reg  [22:0] div_reg;
    reg  [15:0] quo_reg;
    reg         busy_reg;
    reg         done_reg;
    wire [22:0] bits;

    // Total bits of the span; divisor is lanes times bits per byte.
    assign bits   = {7'h00, size} * {17'h0_0000, bpp};
    assign done   = done_reg;
    assign result = quo_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Ceiling division by repeated subtraction, one step per clock.
    always @(posedge clk) begin
        if (reset) begin
            rem_reg  <= 23'h00_0000;
            div_reg  <= 23'h00_0000;
            quo_reg  <= 16'h0000;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start && !busy_reg) begin
                rem_reg  <= bits;
                div_reg  <= {17'h0_0000, width, 3'b000};
                quo_reg  <= 16'h0000;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (rem_reg == 23'h00_0000 || div_reg == 23'h00_0000) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else if (rem_reg <= div_reg) begin
                    quo_reg  <= quo_reg + 16'h0001;
                    rem_reg  <= 23'h00_0000;
                end else begin
                    quo_reg  <= quo_reg + 16'h0001;
                    rem_reg  <= rem_reg - div_reg;
                end
            end
        end
    end
endmodule

//--- hdl/dht_fifo.v
`timescale 1ns/1ns
module dht_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_ptr_reg;
    reg [AW:0]      rd_ptr_reg;
    reg [WIDTH-1:0] out_data_reg;
    reg             out_valid_reg;
    wire            empty;
    wire            full;
    wire            pop;

    // Full and empty come from the extra pointer bit.
    assign empty     = (wr_ptr_reg == rd_ptr_reg);
    assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign in_ready  = !full;
    assign pop       = !empty && (!out_valid_reg || out_ready);
    assign out_data  = out_data_reg;
    assign out_valid = out_valid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Storage writes and a registered output stage.
    always @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
        if (reset) begin
            wr_ptr_reg    <= {(AW+1){1'b0}};
            rd_ptr_reg    <= {(AW+1){1'b0}};
            out_valid_reg <= 1'b0;
            out_data_reg  <= {WIDTH{1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                out_data_reg  <= mem[rd_ptr_reg[AW-1:0]];
                out_valid_reg <= 1'b1;
                rd_ptr_reg    <= rd_ptr_reg + 1'b1;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end
endmodule

//--- hdl/dht_timing.v
`timescale 1ns/1ns
`include "dht_regs.vh"
module dht_timing (
    input  wire        CLK,
    input  wire        RESET,
    input  wire        ENABLE,
    input  wire        CMD_MODE,
    input  wire        SYNC_EVENT,
    input  wire        COMPRESSED,
    input  wire [5:0]  FORMAT_BPP,
    input  wire [2:0]  LANES,
    input  wire [15:0] H_ACTIVE,
    input  wire [15:0] H_SYNC_START,
    input  wire [15:0] H_SYNC_END,
    input  wire [15:0] H_TOTAL,
    output wire [7:0]  LINK_DATA,
    output wire        LINK_TOKEN,
    output wire        LINK_VALID,
    input  wire        LINK_READY,
    output wire [1:0]  REGION,
    output wire        LINE_START,
    output wire        CONFIG_DONE
);
    localparam S_IDLE = 6'b00_0001;
    localparam S_CONV = 6'b00_0010;
    localparam S_ACT  = 6'b00_0100;
    localparam S_FP   = 6'b00_1000;
    localparam S_HS   = 6'b01_0000;
    localparam S_BP   = 6'b10_0000;

    reg  [5:0]  state_reg;
    reg  [1:0]  conv_idx_reg;
    reg         conv_start_reg;
    reg  [15:0] b_act_reg;
    reg  [15:0] b_hss_reg;
    reg  [15:0] b_hse_reg;
    reg  [15:0] b_tot_reg;
    reg  [15:0] hcnt_reg;
    reg  [15:0] hcnt_next;
    reg  [15:0] emit_reg;
    reg  [15:0] region_len_reg;
    reg  [1:0]  region_reg;
    reg         line_start_reg;
    reg         cfg_done_reg;
    reg  [9:0]  fifo_in;
    reg         fifo_in_valid;
    wire        fifo_in_ready;
    wire [9:0]  fifo_out;
    wire        conv_done;
    wire [15:0] conv_result;
    reg  [15:0] conv_size;
    wire [5:0]  eff_bpp;
    wire [15:0] hdr_bytes;
    wire [15:0] budget;
    wire        blank_gap;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion of the four horizontal fields to byte clocks.
    assign eff_bpp = COMPRESSED ? `DHT_COMPRESSED_BPP : FORMAT_BPP;

    // Command mode converts with the same bits per pixel as video mode; CMD_MODE does not enter the ratio.
    always @* begin
        case (conv_idx_reg)
            2'd0:    conv_size = H_ACTIVE + 16'h0001;
            2'd1:    conv_size = H_SYNC_START + 16'h0001;
            2'd2:    conv_size = H_SYNC_END + 16'h0001;
            default: conv_size = H_TOTAL + 16'h0001;
        endcase
    end

    dht_conv u_conv (
        .clk    (CLK),
        .reset  (RESET),
        .start  (conv_start_reg),
        .size   (conv_size),
        .bpp    (eff_bpp),
        .width  (LANES),
        .done   (conv_done),
        .result (conv_result)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bytes the region must give up to packet framing before blanking fill.
    function [15:0] region_overhead;
        input [1:0] rg;
        input       ev;
        begin
            case (rg)
                2'd1:    region_overhead = {8'h00, `DHT_LONG_PKT_OVERHEAD};
                2'd2:    region_overhead = {8'h00, `DHT_SYNC_START_BYTES};
                2'd3:    region_overhead = ev ? {8'h00, `DHT_PIX_HDR_BYTES}
                                              : {8'h00, `DHT_PIX_HDR_BYTES} + {8'h00, `DHT_SYNC_END_BYTES};
                default: region_overhead = 16'h0000;
            endcase
        end
    endfunction

    assign hdr_bytes = region_overhead(region_reg, SYNC_EVENT);
    // Only gaps that would carry blanking may change token; sync packets always go out.
    assign blank_gap = (region_reg == 2'd1) || (region_reg == 2'd3 && SYNC_EVENT);
    // Byte budget of the current region: byte clocks times lanes, less its framing overhead.
    assign budget = (region_len_reg * {13'h0000, LANES}) - hdr_bytes;

    ////////////////////////////////////////////////////////////////////////////
    // Horizontal counter; once running, one step per byte clock in which the FIFO took the last byte.
    always @* begin
        if (hcnt_reg + 16'h0001 >= b_tot_reg) begin
            hcnt_next = 16'h0000;
        end else begin
            hcnt_next = hcnt_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Region sequencing and packet emission into the FIFO.
    always @(posedge CLK) begin
        if (RESET) begin
            state_reg      <= S_IDLE;
            conv_idx_reg   <= 2'd0;
            conv_start_reg <= 1'b0;
            b_act_reg      <= 16'h0000;
            b_hss_reg      <= 16'h0000;
            b_hse_reg      <= 16'h0000;
            b_tot_reg      <= 16'h0000;
            hcnt_reg       <= 16'h0000;
            emit_reg       <= 16'h0000;
            region_len_reg <= 16'h0000;
            region_reg     <= 2'd0;
            line_start_reg <= 1'b0;
            cfg_done_reg   <= 1'b0;
            fifo_in        <= 10'h000;
            fifo_in_valid  <= 1'b0;
        end else begin
            conv_start_reg <= 1'b0;
            line_start_reg <= 1'b0;
            cfg_done_reg   <= 1'b0;
            if (fifo_in_ready) begin
                fifo_in_valid <= 1'b0;
            end
            case (state_reg)
                S_IDLE: begin
                    if (ENABLE) begin
                        conv_idx_reg   <= 2'd0;
                        conv_start_reg <= 1'b1;
                        state_reg      <= S_CONV;
                    end
                end
                S_CONV: begin
                    if (conv_done) begin
                        case (conv_idx_reg)
                            2'd0:    b_act_reg <= conv_result;
                            2'd1:    b_hss_reg <= conv_result;
                            2'd2:    b_hse_reg <= conv_result;
                            default: b_tot_reg <= conv_result;
                        endcase
                        if (conv_idx_reg == 2'd3) begin
                            cfg_done_reg   <= 1'b1;
                            hcnt_reg       <= 16'h0000;
                            region_reg     <= 2'd0;
                            region_len_reg <= b_act_reg;
                            emit_reg       <= 16'h0000;
                            line_start_reg <= 1'b1;
                            state_reg      <= S_ACT;
                        end else begin
                            conv_idx_reg   <= conv_idx_reg + 2'd1;
                            conv_start_reg <= 1'b1;
                        end
                    end
                end
                default: begin
                    // Counter only moves when the FIFO accepted the last byte.
                    if (!ENABLE) begin
                        state_reg <= S_IDLE;
                    end else if (!fifo_in_valid || fifo_in_ready) begin
                        hcnt_reg <= hcnt_next;
                        // Emit the region's opening token, then one filler byte per step outside the active region.
                        if (emit_reg == 16'h0000) begin
                            fifo_in_valid <= 1'b1;
                            case (region_reg)
                                2'd0:    fifo_in <= {2'b01, `DHT_TOK_PIX};
                                2'd2:    fifo_in <= {2'b01, `DHT_TOK_HSS};
                                2'd3:    fifo_in <= SYNC_EVENT ? {2'b01, `DHT_TOK_BLANK}
                                                               : {2'b01, `DHT_TOK_HSE};
                                default: fifo_in <= {2'b01, `DHT_TOK_BLANK};
                            endcase
                            // Long gaps drop to low power; short ones keep HS with blanking.
                            if (blank_gap && budget >= `DHT_LP_MIN_BYTES) begin
                                fifo_in <= {2'b01, `DHT_TOK_LP};
                            end else if (blank_gap && budget < {8'h00, `DHT_MIN_BLANK_PKT}) begin
                                fifo_in <= {2'b01, `DHT_TOK_BLANK};
                            end
                        end else if (region_reg != 2'd0) begin
                            fifo_in_valid <= 1'b1;
                            fifo_in       <= {2'b00, `DHT_BLANK_FILL};
                        end
                        emit_reg <= emit_reg + 16'h0001;
                        // Region changes at converted byte clock boundaries.
                        if (hcnt_next == b_act_reg && region_reg == 2'd0) begin
                            region_reg     <= 2'd1;
                            region_len_reg <= b_hss_reg - b_act_reg;
                            emit_reg       <= 16'h0000;
                            state_reg      <= S_FP;
                        end else if (hcnt_next == b_hss_reg && region_reg == 2'd1) begin
                            region_reg     <= 2'd2;
                            region_len_reg <= b_hse_reg - b_hss_reg;
                            emit_reg       <= 16'h0000;
                            state_reg      <= S_HS;
                        end else if (hcnt_next == b_hse_reg && region_reg == 2'd2) begin
                            region_reg     <= 2'd3;
                            region_len_reg <= b_tot_reg - b_hse_reg;
                            emit_reg       <= 16'h0000;
                            state_reg      <= S_BP;
                        end else if (hcnt_next == 16'h0000) begin
                            region_reg     <= 2'd0;
                            region_len_reg <= b_act_reg;
                            emit_reg       <= 16'h0000;
                            line_start_reg <= 1'b1;
                            state_reg      <= S_ACT;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer toward the link serialiser.
    dht_fifo #(
        .WIDTH (10),
        .DEPTH (`DHT_FIFO_DEPTH),
        .AW    (`DHT_FIFO_AW)
    ) u_fifo (
        .clk       (CLK),
        .reset     (RESET),
        .in_data   (fifo_in),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (LINK_VALID),
        .out_ready (LINK_READY)
    );

    assign LINK_DATA   = fifo_out[7:0];
    assign LINK_TOKEN  = fifo_out[8];
    assign REGION      = region_reg;
    assign LINE_START  = line_start_reg;
    assign CONFIG_DONE = cfg_done_reg;
endmodule

//--- shared/dht_regs.vh
`ifndef DHT_REGS_VH
`define DHT_REGS_VH
// Bits per byte used in the pixel to byte clock conversion.
`define DHT_BITS_PER_BYTE      8
// Format depth forced while the pixel stream is compressed.
`define DHT_COMPRESSED_BPP     6'h18
// Smallest blanking packet in bytes: header, payload above four bytes, CRC.
`define DHT_MIN_BLANK_PKT      8'h0B
// Smallest blanking payload in bytes.
`define DHT_MIN_BLANK_PAYLOAD  8'h05
// Long packet header plus CRC bytes.
`define DHT_LONG_PKT_OVERHEAD  8'h06
// Pixel packet header bytes deducted from the back porch.
`define DHT_PIX_HDR_BYTES      8'h04
// Sync end short packet bytes.
`define DHT_SYNC_END_BYTES     8'h04
// Sync start short packet bytes.
`define DHT_SYNC_START_BYTES   8'h04
// Fewest bytes between bursts that let the link drop to low power.
`define DHT_LP_MIN_BYTES       16'h0040
// Byte stream encodings of region tokens.
`define DHT_TOK_BLANK          8'h19
`define DHT_TOK_HSS            8'h21
`define DHT_TOK_HSE            8'h31
`define DHT_TOK_PIX            8'h3E
`define DHT_TOK_LP             8'h00
// Blanking filler byte.
`define DHT_BLANK_FILL         8'h00
// FIFO depth.
`define DHT_FIFO_DEPTH         16
`define DHT_FIFO_AW            4
`endif

//--- verif/dht_panel_model.sv
`timescale 1ns/1ns
`include "dht_regs.vh"
module dht_panel_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  link_data,
    input  wire logic        link_token,
    input  wire logic        link_valid,
    output wire logic        link_ready,
    input  wire logic        hold,
    input  wire logic        slow,
    output logic      [15:0] n_pix,
    output logic      [15:0] n_hss,
    output logic      [15:0] n_hse,
    output logic      [15:0] n_blk
);
    logic tog;

    // Takes a byte every cycle, every other cycle when slow, and none while held.
    assign link_ready = !hold && !(slow && tog);

    // Counts region tokens; the panel only sees bytes and knows nothing of the link rate.
    always @(posedge clk) begin
        if (reset) begin
            tog   <= 1'b0;
            n_pix <= 16'h0;
            n_hss <= 16'h0;
            n_hse <= 16'h0;
            n_blk <= 16'h0;
        end else begin
            tog <= !tog;
            if (link_valid && link_ready && link_token) begin
                n_pix <= n_pix + {15'h0, link_data == `DHT_TOK_PIX};
                n_hss <= n_hss + {15'h0, link_data == `DHT_TOK_HSS};
                n_hse <= n_hse + {15'h0, link_data == `DHT_TOK_HSE};
                n_blk <= n_blk + {15'h0, link_data == `DHT_TOK_BLANK};
            end
        end
    end
endmodule

//--- verif/dht_timing_assertions.sv
`timescale 1ns/1ns
`include "dht_regs.vh"
module dht_timing_chk (
    input wire logic        CLK,
    input wire logic        RESET,
    input wire logic        ENABLE,
    input wire logic        SYNC_EVENT,
    input wire logic        COMPRESSED,
    input wire logic [5:0]  FORMAT_BPP,
    input wire logic [2:0]  LANES,
    input wire logic [15:0] H_ACTIVE,
    input wire logic [15:0] H_TOTAL,
    input wire logic [7:0]  LINK_DATA,
    input wire logic        LINK_TOKEN,
    input wire logic        LINK_VALID,
    input wire logic        LINK_READY,
    input wire logic [1:0]  REGION,
    input wire logic        LINE_START,
    input wire logic        CONFIG_DONE
);
    reg  [15:0] len_reg;
    reg  [15:0] act_reg;
    reg  [1:0]  nl_reg;
    reg         st_cur_reg;
    reg         st_prev_reg;
    wire        clean;

    // Byte clocks for a zero-based pixel field; compressed streams count as 24 bits.
    function automatic [15:0] conv(input [15:0] f);
        reg [31:0] den;
        reg [31:0] num;
        begin
            den  = {29'h0, LANES} * 32'h0000_0008;
            num  = ({16'h0, f} + 32'h0000_0001) * (COMPRESSED ? 32'h0000_0018 : {26'h0, FORMAT_BPP});
            num  = (num + den - 32'h0000_0001) / den;
            conv = num[15:0];
        end
    endfunction

    ////////////////////////////////////////
    // Measures each line; a line is clean when neither it nor the one before saw a stall.
    always @(posedge CLK) begin
        if (RESET || !ENABLE) begin
            len_reg     <= 16'h0;
            act_reg     <= 16'h0;
            nl_reg      <= 2'h0;
            st_cur_reg  <= 1'b0;
            st_prev_reg <= 1'b0;
        end else if (LINE_START) begin
            len_reg     <= 16'h0001;
            act_reg     <= {15'h0, REGION == 2'h0};
            nl_reg      <= nl_reg + {1'b0, nl_reg != 2'h2};
            st_prev_reg <= st_cur_reg;
            st_cur_reg  <= !LINK_READY;
        end else begin
            len_reg     <= len_reg + 16'h0001;
            act_reg     <= act_reg + {15'h0, REGION == 2'h0};
            st_cur_reg  <= st_cur_reg | !LINK_READY;
        end
    end
    assign clean = (nl_reg == 2'h2) && !st_cur_reg && !st_prev_reg;

    ////////////////////////////////////////
    // All checks share the byte clock and are quiet while reset is asserted.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_line_len;
        LINE_START && clean |-> len_reg == conv(H_TOTAL);
    endproperty
    a_line_len: assert property (p_line_len) else $error("line length differs from converted total");
    property p_active_len;
        LINE_START && clean |-> act_reg == conv(H_ACTIVE);
    endproperty
    a_active_len: assert property (p_active_len) else $error("active span differs from converted size");
    property p_cfg_pulse;
        CONFIG_DONE |=> !CONFIG_DONE;
    endproperty
    a_cfg_pulse: assert property (p_cfg_pulse) else $error("conversion done flag held too long");
    property p_ls_pulse;
        LINE_START |=> !LINE_START [*2];
    endproperty
    a_ls_pulse: assert property (p_ls_pulse) else $error("line start repeated too soon");
    property p_event_no_end;
        LINK_VALID && LINK_TOKEN && SYNC_EVENT |-> LINK_DATA != `DHT_TOK_HSE;
    endproperty
    a_event_no_end: assert property (p_event_no_end) else $error("sync end token sent in event mode");
    property p_token_legal;
        LINK_VALID && LINK_TOKEN |-> LINK_DATA inside
            {`DHT_TOK_BLANK, `DHT_TOK_HSS, `DHT_TOK_HSE, `DHT_TOK_PIX, `DHT_TOK_LP};
    endproperty
    a_token_legal: assert property (p_token_legal) else $error("unknown region token");
    property p_hold;
        LINK_VALID && !LINK_READY |=> LINK_VALID && $stable(LINK_DATA) && $stable(LINK_TOKEN);
    endproperty
    a_hold: assert property (p_hold) else $error("link byte changed before acceptance");
    property p_region_step;
        ENABLE && $past(ENABLE) && REGION != $past(REGION) |-> REGION == $past(REGION) + 2'h1;
    endproperty
    a_region_step: assert property (p_region_step) else $error("region skipped or went back");
    property p_reset_quiet;
        $past(RESET) |-> !LINK_VALID && !LINE_START && !CONFIG_DONE && REGION == 2'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active right after reset");
    property p_idle_quiet;
        !ENABLE && !$past(ENABLE) && !$past(ENABLE, 2) |-> !LINE_START && !CONFIG_DONE;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("activity while disabled");
endmodule

bind dht_timing dht_timing_chk i_chk (.CLK, .RESET, .ENABLE, .SYNC_EVENT, .COMPRESSED, .FORMAT_BPP, .LANES,
    .H_ACTIVE, .H_TOTAL, .LINK_DATA, .LINK_TOKEN, .LINK_VALID, .LINK_READY, .REGION, .LINE_START, .CONFIG_DONE);

//--- verif/tb_dht_timing.sv
`timescale 1ns/1ns
`include "dht_regs.vh"
module tb_dht_timing;
    typedef struct {
        logic        cmd, ev, comp;
        logic [5:0]  bpp;
        logic [2:0]  ln;
        logic [15:0] ha, hs, he, ht, ea, et;
    } dht_row_t;
    logic        CLK, RESET, ENABLE, CMD_MODE, SYNC_EVENT, COMPRESSED, hold, slow;
    logic [5:0]  FORMAT_BPP;
    logic [2:0]  LANES;
    logic [15:0] H_ACTIVE, H_SYNC_START, H_SYNC_END, H_TOTAL, len, act;
    wire  [7:0]  LINK_DATA;
    wire         LINK_TOKEN, LINK_VALID, LINK_READY, LINE_START, CONFIG_DONE;
    wire  [1:0]  REGION;
    wire  [15:0] n_pix, n_hss, n_hse, n_blk;
    int          n_fail, n_checks, i;
    dht_row_t    rows [6];

    dht_timing i_dut (.CLK(CLK), .RESET(RESET), .ENABLE(ENABLE), .CMD_MODE(CMD_MODE), .SYNC_EVENT(SYNC_EVENT),
        .COMPRESSED(COMPRESSED), .FORMAT_BPP(FORMAT_BPP), .LANES(LANES), .H_ACTIVE(H_ACTIVE),
        .H_SYNC_START(H_SYNC_START), .H_SYNC_END(H_SYNC_END), .H_TOTAL(H_TOTAL), .LINK_DATA(LINK_DATA),
        .LINK_TOKEN(LINK_TOKEN), .LINK_VALID(LINK_VALID), .LINK_READY(LINK_READY), .REGION(REGION),
        .LINE_START(LINE_START), .CONFIG_DONE(CONFIG_DONE));
    dht_panel_model i_panel (.clk(CLK), .reset(RESET), .link_data(LINK_DATA), .link_token(LINK_TOKEN),
        .link_valid(LINK_VALID), .link_ready(LINK_READY), .hold(hold), .slow(slow), .n_pix(n_pix),
        .n_hss(n_hss), .n_hse(n_hse), .n_blk(n_blk));

    // Free-running byte clock at 250 MHz.
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    ////////////////////////////////////////
    // Result comparisons, the closing report and bounded waits.
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t count %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_ls;
        int k;
        for (k = 0; k < 4000 && LINE_START !== 1'b1; k++) @(negedge CLK);
        if (LINE_START !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t no line start", $time);
            tally_and_finish();
        end
    endtask
    // Times one line from its start pulse; the panel is held for line cycles a up to b.
    task automatic measure(input logic [15:0] a, input logic [15:0] b);
        wait_ls();
        len = 16'h0;
        act = 16'h0;
        do begin
            hold = (len >= a) && (len < b);
            len = len + 16'h0001;
            act = act + {15'h0, REGION === 2'h0};
            @(negedge CLK);
        end while (LINE_START !== 1'b1 && len < 16'h1000);
        hold = 1'b0;
        if (LINE_START !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t line never ended", $time);
            tally_and_finish();
        end
    endtask
    // Loads a setup under reset, enables and waits for the conversions to finish.
    task automatic start_row(input dht_row_t r);
        int k;
        RESET = 1'b1;
        ENABLE = 1'b0;
        {CMD_MODE, SYNC_EVENT, COMPRESSED, FORMAT_BPP, LANES} = {r.cmd, r.ev, r.comp, r.bpp, r.ln};
        {H_ACTIVE, H_SYNC_START, H_SYNC_END, H_TOTAL} = {r.ha, r.hs, r.he, r.ht};
        repeat (2) @(negedge CLK);
        RESET = 1'b0;
        @(negedge CLK);
        ENABLE = 1'b1;
        for (k = 0; k < 1000 && CONFIG_DONE !== 1'b1; k++) @(negedge CLK);
        chk1(CONFIG_DONE, 1'b1);
        if (CONFIG_DONE !== 1'b1) tally_and_finish();
    endtask

    ////////////////////////////////////////
    // Table of setups, then the stall, idle and mid-line reset cases.
    initial begin
        {RESET, ENABLE, CMD_MODE, SYNC_EVENT, COMPRESSED, hold, slow} = 7'h40;
        {FORMAT_BPP, LANES} = {6'h18, 3'h1};
        {H_ACTIVE, H_SYNC_START, H_SYNC_END, H_TOTAL} = 64'h0;
        n_fail = 0;
        n_checks = 0;
        // Zero-based fields keep every blanking region at or above its lane minimum.
        rows[0] = '{1'b0, 1'b0, 1'b0, 6'h18, 3'h1,
            16'h0013, 16'h001A, 16'h001F, 16'h0026, 16'h003C, 16'h0075};
        rows[1] = '{1'b0, 1'b1, 1'b0, 6'h12, 3'h4,
            16'h003E, 16'h004F, 16'h005F, 16'h006F, 16'h0024, 16'h003F};
        rows[2] = '{1'b1, 1'b0, 1'b1, 6'h10, 3'h2,
            16'h0028, 16'h0038, 16'h0042, 16'h0050, 16'h003E, 16'h007A};
        rows[3] = '{1'b0, 1'b1, 1'b0, 6'h10, 3'h3,
            16'h001D, 16'h002C, 16'h0035, 16'h003F, 16'h0014, 16'h002B};
        // Row 0 with sync start, sync end and total scaled by a 3/2 burst ratio, rounded up.
        rows[4] = '{1'b0, 1'b0, 1'b0, 6'h18, 3'h1,
            16'h0013, 16'h0028, 16'h002F, 16'h003A, 16'h003C, 16'h00B1};
        // A compressed link at half the uncompressed rate halves sync and total, rounded up.
        rows[5] = '{1'b0, 1'b1, 1'b1, 6'h10, 3'h2,
            16'h0013, 16'h0031, 16'h0040, 16'h0054, 16'h001E, 16'h0080};
        repeat (20) @(negedge CLK);
        for (i = 0; i < 6; i++) begin
            start_row(rows[i]);
            repeat (3) measure(16'h0, 16'h0);
            chk16(len, rows[i].et);
            chk16(act, rows[i].ea);
            chk1(n_hse == 16'h0, rows[i].ev);
            chk1(n_pix != 16'h0 && n_hss != 16'h0, 1'b1);
            chk1(n_blk != 16'h0, 1'b1);
            // A command mode line fixes the vertical blank for 400 us of prefetch at 4 ns a byte clock.
            if (rows[i].cmd) chk16(16'((100000 + len - 1) / len), 16'h0334);
        end
        // A held, then a slow panel fills the queue, so the line stretches.
        start_row(rows[0]);
        measure(16'h003D, 16'h00A1);
        chk1(len > 16'h0075, 1'b1);
        slow = 1'b1;
        measure(16'h0, 16'h0);
        chk1(len > 16'h0075, 1'b1);
        slow = 1'b0;
        // Disabled, the block stays idle and the queue drains empty.
        ENABLE = 1'b0;
        len = 16'h0;
        for (i = 0; i < 300; i++) begin
            @(negedge CLK);
            len = len + {15'h0, LINE_START === 1'b1};
        end
        chk16(len, 16'h0);
        chk1(LINK_VALID, 1'b0);
        // A reset in mid-line clears the outputs; the same setup then runs true again.
        ENABLE = 1'b1;
        wait_ls();
        repeat (30) @(negedge CLK);
        RESET = 1'b1;
        repeat (2) @(negedge CLK);
        chk1(LINK_VALID | LINE_START | CONFIG_DONE | (REGION != 2'h0), 1'b0);
        RESET = 1'b0;
        repeat (3) measure(16'h0, 16'h0);
        chk16(len, 16'h0075);
        tally_and_finish();
    end
endmodule
